// *** design/irq_vector_priority_map.sv ***
// Function
// - equal level: lower request number wins
// - each request owns two-bit level field
// - vector FFFA minus two per request
// - external channels 2 and 6 share request 2
// - ext 3/7 to 3, 5 to 1, 4 to 0
// - timer 1 upper to 14, lower to 22
// - timer 0 lower to 5, upper to 6
// - unmapped address: writes ignored, read zero
// - level registers reset to all ones
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module irq_vector_priority_map
	import irq_map_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// peripheral request pulses
	input wire logic [7:0] ext_irq_i,
	input wire logic [1:0] tmr0_irq_i,
	input wire logic [1:0] tmr1_irq_i,
	input wire logic ser_rx_irq_i,
	input wire logic ser_tx_irq_i,
	input wire logic adc_irq_i,
	input wire logic tbt_irq_i,
	input wire logic wps_irq_i,
	input wire logic flash_irq_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// core side
	output logic irq_o,
	output logic [REQ_W-1:0] irq_num_o,
	output logic [LVL_W-1:0] irq_level_o,
	output logic [15:0] irq_vec_hi_addr_o,
	output logic [15:0] irq_vec_lo_addr_o
);
	// ==========================================
	// elaboration checks
	generate
		if (NUM_REQ > LVL_REGS * 4) begin : g_bad_lvl
			$error("level registers too few for the request count");
		end
		if (NUM_REQ > (1 << REQ_W)) begin : g_bad_num
			$error("request number field too narrow");
		end
		if (NUM_REQ > 24) begin : g_bad_bus
			$error("status and mask must fit the low three bus lanes");
		end
		if (LVL_W != 2) begin : g_bad_lvl_w
			$error("level fields are two bits wide");
		end
		if (REQ_FLASH >= NUM_REQ) begin : g_bad_src
			$error("source position beyond the request vector");
		end
		if (OFS_LVL5 != OFS_LVL0 + 8'(4 * (LVL_REGS - 1))) begin : g_bad_ofs
			$error("level registers must sit one word apart");
		end
	endgenerate

	// ==========================================
	// request routing
	logic [NUM_REQ-1:0] raw_req;
	always_comb begin
		raw_req = '0;
		// external channels
		raw_req[REQ_EXT4] = ext_irq_i[4];
		raw_req[REQ_EXT5] = ext_irq_i[5];
		raw_req[REQ_EXT26] = ext_irq_i[2] | ext_irq_i[6];
		raw_req[REQ_EXT37] = ext_irq_i[3] | ext_irq_i[7];

		// composite timers
		raw_req[REQ_T0_LO] = tmr0_irq_i[0];
		raw_req[REQ_T0_HI] = tmr0_irq_i[1];
		raw_req[REQ_T1_LO] = tmr1_irq_i[0];
		raw_req[REQ_T1_HI] = tmr1_irq_i[1];

		// other sources
		raw_req[REQ_SER_RX] = ser_rx_irq_i;
		raw_req[REQ_SER_TX] = ser_tx_irq_i;
		raw_req[REQ_ADC] = adc_irq_i;
		raw_req[REQ_TBT] = tbt_irq_i;
		raw_req[REQ_WPS] = wps_irq_i;
		raw_req[REQ_FLASH] = flash_irq_i;
	end

	// ==========================================
	// state
	logic [7:0] lvl_q [LVL_REGS];
	logic [7:0] lvl_d [LVL_REGS];
	logic [NUM_REQ-1:0] stat_q;
	logic [NUM_REQ-1:0] stat_d;
	logic [NUM_REQ-1:0] mask_q;
	logic [NUM_REQ-1:0] mask_d;

	// bus side
	logic ack_d;
	logic [31:0] rdat_d;

	// core side
	logic irq_d;
	logic [REQ_W-1:0] num_d;
	logic [LVL_W-1:0] lvl_out_d;
	logic [15:0] vhi_d;
	logic [15:0] vlo_d;

	// ==========================================
	// bus decode
	logic bus_req;
	logic bus_wr;
	logic bus_rd;
	logic hit_lvl;
	logic hit_stat;
	logic hit_mask;
	logic hit_vec;
	logic [2:0] lvl_idx;
	logic [31:0] wmask;
	logic [NUM_REQ-1:0] lane_mask;
	logic [NUM_REQ-1:0] wr_bits;

	// a request is taken once; its acked cycle is not taken again
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr = bus_req & wb_we_i;
	assign bus_rd = bus_req & ~wb_we_i;
	assign lvl_idx = wb_adr_i[4:2];
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign lane_mask = wmask[NUM_REQ-1:0];
	assign wr_bits = wb_dat_i[NUM_REQ-1:0] & lane_mask;

	always_comb begin
		hit_lvl = 1'b0;
		hit_stat = 1'b0;
		hit_mask = 1'b0;
		hit_vec = 1'b0;
		if (wb_adr_i <= OFS_LVL5 && wb_adr_i[1:0] == 2'b00) begin
			hit_lvl = 1'b1;
		end else if (wb_adr_i == OFS_STAT) begin
			hit_stat = 1'b1;
		end else if (wb_adr_i == OFS_MASK) begin
			hit_mask = 1'b1;
		end else if (wb_adr_i == OFS_VEC) begin
			hit_vec = 1'b1;
		end
		// holes: writes dropped, reads zero
	end

	// two-bit level per request, four per byte
	logic [LVL_W-1:0] lvl_of [NUM_REQ];
	genvar g;
	generate
		for (g = 0; g < NUM_REQ; g++) begin : g_lvl
			assign lvl_of[g] = lvl_q[g/4][(g%4)*2 +: 2];
		end
	endgenerate

	// vector table, one upper address per request
	logic [15:0] vec_tab [NUM_REQ];
	generate
		for (g = 0; g < NUM_REQ; g++) begin : g_vec
			assign vec_tab[g] = VEC_TOP - 16'(g) * VEC_STEP;
		end
	endgenerate

	// ==========================================
	// level registers
	always_comb begin
		for (int r = 0; r < LVL_REGS; r++) begin
			lvl_d[r] = lvl_q[r];
		end
		// only byte lane 0 carries the four fields
		if (bus_wr && hit_lvl && wb_sel_i[0]) begin
			lvl_d[lvl_idx] = wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int r = 0; r < LVL_REGS; r++) begin
				lvl_q[r] <= LVL_RESET;
			end
		end else if (ce_i) begin
			lvl_q <= lvl_d;
		end
	end

	// ==========================================
	// sticky status, write one to clear
	// mask: a one lets the bit reach irq_o
	always_comb begin
		stat_d = stat_q;
		mask_d = mask_q;
		if (bus_wr && hit_stat) begin
			stat_d = stat_q & ~wr_bits;
		end
		if (bus_wr && hit_mask) begin
			mask_d = (mask_q & ~lane_mask) | wr_bits;
		end
		// new events win over a same-cycle clear
		stat_d = stat_d | raw_req;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_q <= '0;
			mask_q <= MASK_RESET;
		end else if (ce_i) begin
			stat_q <= stat_d;
			mask_q <= mask_d;
		end
	end

	// ==========================================
	// arbitration: lower level value is more urgent,
	// ties go to the lowest request number
	logic [NUM_REQ-1:0] pend;
	logic found;
	logic [REQ_W-1:0] win_num;
	logic [LVL_W-1:0] win_lvl;
	assign pend = stat_q & mask_q;
	always_comb begin
		found = 1'b0;
		win_num = '0;
		win_lvl = '1;
		for (int i = 0; i < NUM_REQ; i++) begin
			if (pend[i] && (!found || lvl_of[i] < win_lvl)) begin
				found = 1'b1;
				win_num = REQ_W'(i);
				win_lvl = lvl_of[i];
			end
		end
	end

	// ==========================================
	// vector of the current winner
	always_comb begin
		irq_d = found;
		num_d = win_num;
		lvl_out_d = win_lvl;
		vhi_d = vec_tab[win_num];
		vlo_d = vhi_d + 16'h0001;
	end

	// ==========================================
	// bus answer, one cycle after the request is taken
	always_comb begin
		ack_d = bus_req;
		rdat_d = UNMAPPED_DATA;
		if (bus_rd) begin
			if (hit_lvl) begin
				rdat_d = {24'h000000, lvl_q[lvl_idx]};
			end else if (hit_stat) begin
				rdat_d = {8'h00, stat_q};
			end else if (hit_mask) begin
				rdat_d = {8'h00, mask_q};
			end else if (hit_vec) begin
				rdat_d = {found, 2'b00, win_lvl, 3'b000, win_num, 3'b000, vhi_d};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= ack_d;
			wb_dat_o <= rdat_d;
		end
	end

	// ==========================================
	// core side outputs, one cycle behind status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			irq_num_o <= '0;
			irq_level_o <= '0;
			irq_vec_hi_addr_o <= VEC_TOP;
			irq_vec_lo_addr_o <= VEC_TOP + 16'h0001;
		end else if (ce_i) begin
			irq_o <= irq_d;
			irq_num_o <= num_d;
			irq_level_o <= lvl_out_d;
			irq_vec_hi_addr_o <= vhi_d;
			irq_vec_lo_addr_o <= vlo_d;
		end
	end
endmodule
`default_nettype wire

// *** design/irq_map_pkg.sv ***
`default_nettype none
package irq_map_pkg;
	// ==========================================
	// request numbering
	localparam int NUM_REQ = 24;
	localparam int REQ_W = 5;
	localparam int LVL_W = 2;
	localparam logic [15:0] VEC_TOP = 16'hFFFA;
	localparam logic [15:0] VEC_STEP = 16'h0002;
	// source positions on the request vector
	localparam int REQ_EXT4 = 0;
	localparam int REQ_EXT5 = 1;
	localparam int REQ_EXT26 = 2;
	localparam int REQ_EXT37 = 3;
	localparam int REQ_T0_LO = 5;
	localparam int REQ_T0_HI = 6;
	localparam int REQ_SER_RX = 7;
	localparam int REQ_SER_TX = 8;
	localparam int REQ_T1_HI = 14;
	localparam int REQ_ADC = 18;
	localparam int REQ_TBT = 19;
	localparam int REQ_WPS = 20;
	localparam int REQ_T1_LO = 22;
	localparam int REQ_FLASH = 23;
	// ==========================================
	// register map (byte addresses)
	localparam logic [7:0] OFS_LVL0 = 8'h00;
	localparam logic [7:0] OFS_LVL5 = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam logic [7:0] OFS_MASK = 8'h1C;
	localparam logic [7:0] OFS_VEC = 8'h20;
	localparam int LVL_REGS = 6;
	localparam logic [7:0] LVL_RESET = 8'hFF;
	localparam logic [23:0] MASK_RESET = 24'h000000;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage
`default_nettype wire

// *** tb/irq_map_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_map_chk
	import irq_map_pkg::*;
(
	// watched ports
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq_o,
	input wire logic [REQ_W-1:0] irq_num_o,
	input wire logic [15:0] irq_vec_hi_addr_o,
	input wire logic [15:0] irq_vec_lo_addr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	vec_pair_a: assert property (irq_vec_lo_addr_o == irq_vec_hi_addr_o + 16'h1)
		else $error("vector pair");
	vec_step_a: assert property (irq_vec_hi_addr_o == 16'hFFFA - {10'h0, irq_num_o, 1'b0})
		else $error("vector step");
	unused_num_a: assert property (irq_o |-> !(irq_num_o inside {5'h04, 5'h15,
		[5'h09:5'h0D], [5'h0F:5'h11]})) else $error("unassigned request");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
	hole_read_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h30
		|-> wb_dat_o == 32'h0) else $error("hole read");
	reset_vec_a: assert property ($fell(rst_i) |-> !irq_o && irq_vec_hi_addr_o == 16'hFFFA)
		else $error("reset vector");
	cover property (irq_o && irq_num_o == 5'h17);
	cover property (irq_o && irq_num_o == 5'h00);
	cover property (wb_ack_o && wb_we_i);
endmodule
`default_nettype wire

// *** tb/core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic clk_i,
	input wire logic irq_i,
	input wire logic [15:0] vec_i,
	output var logic [15:0] fetch_o
);
	// fetch the upper vector address while a request waits
	always_ff @(posedge clk_i) begin
		if (irq_i) begin
			fetch_o <= vec_i;
		end
	end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import irq_map_pkg::*;
	// source bits: flash wps tbt adc tx rx t1hi t1lo t0hi t0lo ext7..ext0
	localparam logic [89:0] MAP = {5'h17, 5'h14, 5'h13, 5'h12, 5'h08, 5'h07, 5'h0E, 5'h16,
		5'h06, 5'h05, 5'h03, 5'h02, 5'h01, 5'h00, 5'h03, 5'h02, 5'h1F, 5'h1F};
	logic clk, rst, cyc, stb, we, ack, irq;
	logic ce, mask_on;
	logic [7:0] adr;
	logic [31:0] wd, rd, r;
	logic [17:0] src, m;
	logic [4:0] num;
	logic [1:0] lvl;
	logic [15:0] vh, fetch;
	int fails, num_checks;
	irq_vector_priority_map irq_vector_priority_map_i (.clk_i(clk), .rst_i(rst), .ce_i(ce),
		.ext_irq_i(src[7:0]), .tmr0_irq_i(src[9:8]), .tmr1_irq_i(src[11:10]),
		.ser_rx_irq_i(src[12]), .ser_tx_irq_i(src[13]), .adc_irq_i(src[14]),
		.tbt_irq_i(src[15]), .wps_irq_i(src[16]), .flash_irq_i(src[17]), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
		.wb_dat_o(rd), .wb_ack_o(ack), .irq_o(irq), .irq_num_o(num), .irq_level_o(lvl),
		.irq_vec_hi_addr_o(vh), .irq_vec_lo_addr_o());
	core_model core_model_i (.clk_i(clk), .irq_i(irq), .vec_i(vh), .fetch_o(fetch));
	function automatic logic [4:0] win(input logic [17:0] s);
		logic [4:0] b;
		b = 5'h1F;
		for (int i = 2; i < 18; i++) begin
			if (s[i] && MAP[i*5 +: 5] < b) b = MAP[i*5 +: 5];
		end
		return b;
	endfunction
	task automatic chk(input logic [36:0] s, input logic [36:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		r = rd;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic pulse(input logic [17:0] s);
		logic [4:0] b;
		@(posedge clk);
		src <= s;
		@(posedge clk);
		src <= '0;
		repeat (3) @(posedge clk);
		b = win(s);
		chk(irq, b != 5'h1F && mask_on);
		if (b != 5'h1F && mask_on) chk({num, vh, fetch}, {b, {2{16'hFFFA - {10'h0, b, 1'b0}}}});
	endtask
	task automatic wrap_up;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		wrap_up;
	end
	initial begin
		{rst, cyc, stb, we, adr, wd, src} = {1'b1, 61'h0};
		ce = 1'b1;
		mask_on = 1'b0;
		void'($urandom(9524));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		wb(0, OFS_LVL0, 0);
		chk(r[7:0], 8'hFF);
		wb(0, 8'h30, 0);
		chk(r, 32'h0);
		// masked event must stay quiet until unmasked
		pulse(18'h04000);
		wb(1, OFS_MASK, 32'hFFFFFF);
		mask_on = 1'b1;
		repeat (2) @(posedge clk);
		chk({irq, num}, {1'b1, 5'h12});
		for (int i = 0; i < 38; i++) begin
			wb(1, OFS_STAT, 32'hFFFFFF);
			m = (i < 18) ? 18'h1 << i : (18'h1 << ($urandom % 18)) | (18'h1 << ($urandom % 18));
			pulse(m);
		end
		wb(1, OFS_STAT, 32'hFFFFFF);
		// an event seen only while frozen is lost
		@(posedge clk);
		{ce, src} <= {1'b0, 18'h04000};
		@(posedge clk);
		src <= '0;
		@(posedge clk);
		ce <= 1'b1;
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		wb(1, OFS_LVL5, 32'h3F);
		wb(0, OFS_LVL5, 0);
		chk(r[7:0], 8'h3F);
		@(posedge clk);
		src <= 18'h20010;
		@(posedge clk);
		src <= '0;
		repeat (3) @(posedge clk);
		chk({num, lvl}, {5'h17, 2'h0});
		wrap_up;
	end
endmodule
bind irq_vector_priority_map irq_map_chk irq_map_chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .irq_num_o(irq_num_o),
	.irq_vec_hi_addr_o(irq_vec_hi_addr_o), .irq_vec_lo_addr_o(irq_vec_lo_addr_o));
`default_nettype wire
